// ===== core/ir_xcvr_cfg_pkg.sv
// package: register map, field positions, reset values and timing for the ir transceiver configuration block
package ir_xcvr_cfg_pkg;
   // ----------------------------------------------------------------
   // register indices (printed offsets, byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [3:0] IDX_LINK_CONTROL_BANK_SELECT = 4'h3;
   localparam logic [3:0] IDX_RESERVED_BANK7_SLOT      = 4'h5;
   localparam logic [3:0] IDX_IR_RECEIVE_PATH_CONFIG   = 4'h7;
   // registers with no printed offset, placed in free slots
   localparam logic [3:0] IDX_CONSUMER_IR_CONFIG       = 4'h8;
   localparam logic [3:0] IDX_IR_TRANSCEIVER_CONFIG_ONE = 4'h9;
   localparam logic [3:0] IDX_CONSUMER_IR_XCVR_CONFIG  = 4'hA;
   localparam logic [3:0] IDX_MODE_STATUS              = 4'hB;
   localparam int         ADDR_LSB                     = 2;
   localparam int         ADDR_W                       = 6;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CIR_RX_HIGH_CARRIER = 5;
   localparam int CIR_RX_OVERSAMPLE   = 6;
   localparam int CIR_RUN_LENGTH      = 7;
   localparam int CIR_RSVD_BIT        = 3;
   localparam int TC1_IDENT_LO        = 0;
   localparam int TC1_IDENT3          = 3;
   localparam int TC1_SIR_LO          = 4;
   localparam int TC1_PULSE           = 7;
   localparam int CXC_LOW_LO          = 0;
   localparam int CXC_HIGH_LO         = 4;
   localparam int RPC_HI_DIR          = 3;
   localparam int RPC_RX_INVERT       = 4;
   localparam int RPC_SEL0_DIR        = 5;
   localparam int RPC_AUTO_CFG        = 7;

   // ----------------------------------------------------------------
   // masks and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CIR_WMASK   = 8'hF7;
   localparam logic [7:0] CXC_WMASK   = 8'h77;
   localparam logic [7:0] RPC_WMASK   = 8'hB8;
   localparam logic [7:0] RESET_BYTE  = 8'h00;
   localparam logic [2:0] RESET_SEL   = 3'h0;

   // ----------------------------------------------------------------
   // infrared modes and timing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {MODE_OTHER, MODE_SIR, MODE_ASK, MODE_CONSUMER} ir_mode_t;
   localparam int CLK_MHZ         = 125;
   localparam int PULSE_TIME_US   = 64;
   localparam int PULSE_CYCLES    = PULSE_TIME_US * CLK_MHZ;
endpackage

// ===== core/ir_transceiver_config.sv
// ir transceiver configuration registers, select-pin control, receive path selection and transmit pulse timer
// Function
// - cfg bit5 picks low or high carrier band
// - cfg bit6 picks period sampling or oversampling
// - cfg bit7 enables 8-bit run-length coding
// - select0 input: ident bit0 reads pin
// - select0 output: ident bit0 drives pin
// - ident bits2-1 same for select2/select1 pins
// - ident3 bit reads ident3 pin, write-ignored
// - sir values drive pins in auto sir
// - pulse bit forces transmit high 64us
// - consumer transceiver config resets to zero
// - consumer low values drive pins, low band
// - consumer high values drive pins, high band
// - bit3 sets select2/select1 pin direction
// - bit4 inverts receiver input
// - bit5 sets select0 pin direction
// - bit7 enables automatic select value choice
// - receiver input selects first or second pin
// - low ident bits read adaptor identification
// - link control/bank select as bank 0
`timescale 1ns/1ps

module ir_transceiver_config #(
   parameter int PULSE_CYCLES = ir_xcvr_cfg_pkg::PULSE_CYCLES
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [5:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // mode control and bank 0 link
   input  wire logic [1:0]  ir_mode,
   input  wire logic        aux_receive_select,
   input  wire logic [7:0]  link_control_bank_select_rd,
   output logic             link_control_bank_select_wr,
   output logic [7:0]       link_control_bank_select_wdata,
   // transceiver pins
   input  wire logic        select0_rx2_pin_in,
   output logic             select0_rx2_pin_out,
   output logic             select0_rx2_pin_oe_n,
   input  wire logic [1:0]  select_hi_pins_in,
   output logic [1:0]       select_hi_pins_out,
   output logic             select_hi_pins_oe_n,
   input  wire logic        ident3_pin,
   input  wire logic        ir_receive_first,
   output logic             ir_transmit_out,
   // receive path towards the demodulator
   output logic             rx_data,
   output logic             rx_high_carrier_sel,
   output logic             rx_oversample_sel,
   output logic             run_length_enable
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] sync_a;
   logic [5:0] sync_b;
   logic [5:0] pins_raw;

   assign pins_raw = {ir_receive_first, ident3_pin, select_hi_pins_in, select0_rx2_pin_in, 1'b0};

   // two stages; only sync_b is looked at by logic
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync_a <= 6'h00;
         sync_b <= 6'h00;
      end
      else
      begin
         sync_a <= pins_raw;
         sync_b <= sync_a;
      end
   end

   logic       s_rx1;
   logic       s_id3;
   logic [1:0] s_hi;
   logic       s_sel0;
   assign s_rx1  = sync_b[5];
   assign s_id3  = sync_b[4];
   assign s_hi   = sync_b[3:2];
   assign s_sel0 = sync_b[1];

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic [3:0] idx;
   logic       wr_en;
   logic       rd_en;
   logic       mapped;
   logic [7:0] wb;

   assign idx    = paddr[5:2];
   assign wb     = pwdata[7:0];
   assign wr_en  = psel && penable && pwrite;
   assign rd_en  = psel && penable && !pwrite;
   // single-cycle access phase, never wait states
   assign pready = 1'b1;
   assign mapped = (idx == ir_xcvr_cfg_pkg::IDX_LINK_CONTROL_BANK_SELECT)
                || (idx == ir_xcvr_cfg_pkg::IDX_RESERVED_BANK7_SLOT)
                || (idx == ir_xcvr_cfg_pkg::IDX_IR_RECEIVE_PATH_CONFIG)
                || (idx == ir_xcvr_cfg_pkg::IDX_CONSUMER_IR_CONFIG)
                || (idx == ir_xcvr_cfg_pkg::IDX_IR_TRANSCEIVER_CONFIG_ONE)
                || (idx == ir_xcvr_cfg_pkg::IDX_CONSUMER_IR_XCVR_CONFIG)
                || (idx == ir_xcvr_cfg_pkg::IDX_MODE_STATUS);
   // unaligned or unmapped accesses flag an error
   assign pslverr = psel && penable && (!mapped || (paddr[1:0] != 2'h0));

   // link control / bank select is forwarded to the shared bank 0 copy
   assign link_control_bank_select_wr    = wr_en && !pslverr
                                        && (idx == ir_xcvr_cfg_pkg::IDX_LINK_CONTROL_BANK_SELECT);
   assign link_control_bank_select_wdata = wb;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [7:0] consumer_ir_config;
   logic [7:0] consumer_ir_transceiver_config;
   logic [7:0] ir_receive_path_config;
   logic [2:0] ident_ctl;     // written drive values for select pins 2..0
   logic [2:0] sir_select_values;

   logic auto_config_enable;
   logic select_hi_pins_dir;
   logic select0_pin_dir;
   logic rx_input_invert;
   assign select_hi_pins_dir = ir_receive_path_config[ir_xcvr_cfg_pkg::RPC_HI_DIR];
   assign rx_input_invert    = ir_receive_path_config[ir_xcvr_cfg_pkg::RPC_RX_INVERT];
   assign select0_pin_dir    = ir_receive_path_config[ir_xcvr_cfg_pkg::RPC_SEL0_DIR];
   assign auto_config_enable = ir_receive_path_config[ir_xcvr_cfg_pkg::RPC_AUTO_CFG];

   // consumer-ir configuration; reserved bit held at zero
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         consumer_ir_config <= ir_xcvr_cfg_pkg::RESET_BYTE;
      else if (wr_en && idx == ir_xcvr_cfg_pkg::IDX_CONSUMER_IR_CONFIG)
         consumer_ir_config <= wb & ir_xcvr_cfg_pkg::CIR_WMASK;
   end

   assign rx_high_carrier_sel = consumer_ir_config[ir_xcvr_cfg_pkg::CIR_RX_HIGH_CARRIER];
   assign rx_oversample_sel   = consumer_ir_config[ir_xcvr_cfg_pkg::CIR_RX_OVERSAMPLE];
   assign run_length_enable   = consumer_ir_config[ir_xcvr_cfg_pkg::CIR_RUN_LENGTH];

   // consumer-ir transceiver configuration, zero after reset
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         consumer_ir_transceiver_config <= ir_xcvr_cfg_pkg::RESET_BYTE;
      else if (wr_en && idx == ir_xcvr_cfg_pkg::IDX_CONSUMER_IR_XCVR_CONFIG)
         consumer_ir_transceiver_config <= wb & ir_xcvr_cfg_pkg::CXC_WMASK;
   end

   // receive path configuration
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         ir_receive_path_config <= ir_xcvr_cfg_pkg::RESET_BYTE;
      else if (wr_en && idx == ir_xcvr_cfg_pkg::IDX_IR_RECEIVE_PATH_CONFIG)
         ir_receive_path_config <= wb & ir_xcvr_cfg_pkg::RPC_WMASK;
   end

   // identification/control bits: a write lands only on pins set as outputs
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         ident_ctl         <= ir_xcvr_cfg_pkg::RESET_SEL;
         sir_select_values <= ir_xcvr_cfg_pkg::RESET_SEL;
      end
      else if (wr_en && idx == ir_xcvr_cfg_pkg::IDX_IR_TRANSCEIVER_CONFIG_ONE)
      begin
         if (select0_pin_dir)
            ident_ctl[0] <= wb[ir_xcvr_cfg_pkg::TC1_IDENT_LO];
         if (select_hi_pins_dir)
            ident_ctl[2:1] <= wb[ir_xcvr_cfg_pkg::TC1_IDENT_LO + 1 +: 2];
         sir_select_values <= wb[ir_xcvr_cfg_pkg::TC1_SIR_LO +: 3];
      end
   end

   // ----------------------------------------------------------------
   // special transceiver pulse timer
   // ----------------------------------------------------------------
   localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
   logic [CNT_W-1:0] pulse_cnt;
   logic             special_transceiver_pulse;
   logic             pulse_write;

   assign pulse_write = wr_en && idx == ir_xcvr_cfg_pkg::IDX_IR_TRANSCEIVER_CONFIG_ONE
                     && wb[ir_xcvr_cfg_pkg::TC1_PULSE];

   // each write of one reloads the full period; writing zero is ignored.
   // a software loop of restarts can hold the led on indefinitely.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         pulse_cnt                 <= '0;
         special_transceiver_pulse <= 1'b0;
      end
      else if (pulse_write)
      begin
         pulse_cnt                 <= CNT_W'(PULSE_CYCLES - 1);
         special_transceiver_pulse <= 1'b1;
      end
      else if (special_transceiver_pulse)
      begin
         if (pulse_cnt == '0)
            special_transceiver_pulse <= 1'b0;
         else
            pulse_cnt <= pulse_cnt - 1'b1;
      end
   end

   assign ir_transmit_out = special_transceiver_pulse;

   // ----------------------------------------------------------------
   // select pin drive values
   // ----------------------------------------------------------------
   logic [2:0] next_select;
   logic       mode_drive;

   // auto mode picks a value set by ir mode; otherwise the written bits drive
   always_comb
   begin
      next_select = ident_ctl;
      mode_drive  = 1'b1;
      if (auto_config_enable)
      begin
         case (ir_xcvr_cfg_pkg::ir_mode_t'(ir_mode))
            ir_xcvr_cfg_pkg::MODE_ASK:
               next_select = ident_ctl;
            ir_xcvr_cfg_pkg::MODE_SIR:
               next_select = sir_select_values;
            ir_xcvr_cfg_pkg::MODE_CONSUMER:
               if (rx_high_carrier_sel)
                  next_select = consumer_ir_transceiver_config[ir_xcvr_cfg_pkg::CXC_HIGH_LO +: 3];
               else
                  next_select = consumer_ir_transceiver_config[ir_xcvr_cfg_pkg::CXC_LOW_LO +: 3];
            default:
               mode_drive = 1'b0;
         endcase
      end
   end

   // pins are registered so data outputs never glitch; hold previous value when undriven mode
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         select0_rx2_pin_out <= 1'b0;
         select_hi_pins_out  <= 2'h0;
      end
      else if (mode_drive)
      begin
         select0_rx2_pin_out <= next_select[0];
         select_hi_pins_out  <= next_select[2:1];
      end
   end

   // output enables are active low
   assign select0_rx2_pin_oe_n = !select0_pin_dir;
   assign select_hi_pins_oe_n  = !select_hi_pins_dir;

   // ----------------------------------------------------------------
   // receive input selection and inversion
   // ----------------------------------------------------------------
   logic rx_pick;
   // output direction with aux select is undefined; first pin is used then
   assign rx_pick = (!select0_pin_dir && aux_receive_select) ? s_sel0 : s_rx1;

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rx_data <= 1'b0;
      else
         rx_data <= rx_pick ^ rx_input_invert;
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   logic [7:0] tc1_read;
   logic [7:0] rd_byte;

   // ident bits show pin levels while inputs, written values while outputs
   assign tc1_read = {special_transceiver_pulse, sir_select_values, s_id3,
                      select_hi_pins_dir ? ident_ctl[2:1] : s_hi,
                      select0_pin_dir ? ident_ctl[0] : s_sel0};

   always_comb
   begin
      rd_byte = 8'h00;
      case (idx)
         ir_xcvr_cfg_pkg::IDX_LINK_CONTROL_BANK_SELECT:  rd_byte = link_control_bank_select_rd;
         ir_xcvr_cfg_pkg::IDX_IR_RECEIVE_PATH_CONFIG:    rd_byte = ir_receive_path_config;
         ir_xcvr_cfg_pkg::IDX_CONSUMER_IR_CONFIG:        rd_byte = consumer_ir_config;
         ir_xcvr_cfg_pkg::IDX_IR_TRANSCEIVER_CONFIG_ONE: rd_byte = tc1_read;
         ir_xcvr_cfg_pkg::IDX_CONSUMER_IR_XCVR_CONFIG:   rd_byte = consumer_ir_transceiver_config;
         ir_xcvr_cfg_pkg::IDX_MODE_STATUS:               rd_byte = {6'h00, ir_mode};
         default:                                        rd_byte = 8'h00;
      endcase
   end

   // read data registered on the access edge is too late for apb; drive from the mux
   assign prdata = rd_en ? {24'h000000, rd_byte} : 32'h00000000;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_pulse_start;
      pulse_write;
   endsequence

   a_pulse_high: assert property (@(posedge mclk) disable iff (!rstn)
      s_pulse_start |=> ir_transmit_out)
      else $error("transmit pulse not raised");

   a_pulse_ends: assert property (@(posedge mclk) disable iff (!rstn)
      (special_transceiver_pulse && pulse_cnt == '0 && !pulse_write) |=> !ir_transmit_out)
      else $error("transmit pulse did not end");

   a_pulse_reload: assert property (@(posedge mclk) disable iff (!rstn)
      pulse_write |=> (pulse_cnt == CNT_W'(PULSE_CYCLES - 1)))
      else $error("pulse timer not reloaded");

   a_zero_write_inert: assert property (@(posedge mclk) disable iff (!rstn)
      (!special_transceiver_pulse && !pulse_write) |=> !ir_transmit_out)
      else $error("pulse rose without a write of one");

   a_sel0_oe_dir: assert property (@(posedge mclk) disable iff (!rstn)
      select0_rx2_pin_oe_n == !ir_receive_path_config[ir_xcvr_cfg_pkg::RPC_SEL0_DIR])
      else $error("select0 enable disagrees with direction");

   a_sir_drive: assert property (@(posedge mclk) disable iff (!rstn)
      (auto_config_enable && ir_mode == 2'(ir_xcvr_cfg_pkg::MODE_SIR)) |=>
         ($past(sir_select_values[2:1]) == select_hi_pins_out))
      else $error("sir values not on select pins");

   a_cir_low_drive: assert property (@(posedge mclk) disable iff (!rstn)
      (auto_config_enable && ir_mode == 2'(ir_xcvr_cfg_pkg::MODE_CONSUMER) && !rx_high_carrier_sel) |=>
         (select0_rx2_pin_out == $past(consumer_ir_transceiver_config[0])))
      else $error("consumer low value not on select0");

   a_rx_invert: assert property (@(posedge mclk) disable iff (!rstn)
      (!select0_pin_dir && aux_receive_select) |=> (rx_data == ($past(s_sel0) ^ $past(rx_input_invert))))
      else $error("second receive path wrong");

   a_input_ignore: assert property (@(posedge mclk) disable iff (!rstn)
      (!select0_pin_dir) |=> $stable(ident_ctl[0]))
      else $error("ident bit0 written while input");

   a_cir_high_drive: assert property (@(posedge mclk) disable iff (!rstn)
      (auto_config_enable && ir_mode == 2'(ir_xcvr_cfg_pkg::MODE_CONSUMER) && rx_high_carrier_sel) |=>
         (select_hi_pins_out == $past(consumer_ir_transceiver_config[ir_xcvr_cfg_pkg::CXC_HIGH_LO + 1 +: 2])))
      else $error("consumer high values not on select pins");

   a_manual_drive: assert property (@(posedge mclk) disable iff (!rstn)
      !auto_config_enable |=> (select0_rx2_pin_out == $past(ident_ctl[0])))
      else $error("written bit not on select0 with automatic choice off");

endmodule // ir_transceiver_config

// ===== sim/optical_xcvr_model.sv
// optical transceiver model seen across the select, identification and receive pins
`timescale 1ns/1ps

module optical_xcvr_model (
   // pins as the design drives them
   input  wire logic       sel0_out,
   input  wire logic       sel0_oe_n,
   input  wire logic [1:0] hi_out,
   input  wire logic       hi_oe_n,
   // levels the module presents
   input  wire logic [3:0] ident_code,
   input  wire logic       show_rx2,
   input  wire logic       rx1_level,
   input  wire logic       rx2_level,
   // resolved wire levels
   output logic            sel0_wire,
   output logic [1:0]      hi_wire,
   output logic            ident3,
   output logic            rx1
);
   // module drives a shared pin only while the design has released it
   assign sel0_wire = sel0_oe_n ? (show_rx2 ? rx2_level : ident_code[0]) : sel0_out;
   assign hi_wire   = hi_oe_n ? ident_code[2:1] : hi_out;
   assign ident3    = ident_code[3];
   assign rx1       = rx1_level;
endmodule // optical_xcvr_model

// ===== sim/tb_top.sv
// self-checking bench for the ir transceiver configuration block
`timescale 1ns/1ps

module tb_top;
   localparam int P = 40;
   logic       mclk, rstn, psel, penable, pwrite, pready, pslverr, aux, lcbs_wr;
   logic [5:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] ir_mode, hi_out, hi_wire;
   logic [7:0] lcbs_rd, lcbs_wdata, rd;
   logic       sel0_out, sel0_oe_n, hi_oe_n, sel0_wire, ident3, rx1, tx, rx_data;
   logic       hc, ov, rl, show_rx2, rx1_lvl, rx2_lvl, err, lw;
   logic [3:0] id_code;
   int         fail_count, total_checks, cnt;

   ir_transceiver_config #(.PULSE_CYCLES(P)) u_dut (.mclk(mclk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ir_mode(ir_mode), .aux_receive_select(aux),
      .link_control_bank_select_rd(lcbs_rd), .link_control_bank_select_wr(lcbs_wr),
      .link_control_bank_select_wdata(lcbs_wdata), .select0_rx2_pin_in(sel0_wire),
      .select0_rx2_pin_out(sel0_out), .select0_rx2_pin_oe_n(sel0_oe_n), .select_hi_pins_in(hi_wire),
      .select_hi_pins_out(hi_out), .select_hi_pins_oe_n(hi_oe_n), .ident3_pin(ident3),
      .ir_receive_first(rx1), .ir_transmit_out(tx), .rx_data(rx_data), .rx_high_carrier_sel(hc),
      .rx_oversample_sel(ov), .run_length_enable(rl));

   optical_xcvr_model u_xcvr (.sel0_out(sel0_out), .sel0_oe_n(sel0_oe_n), .hi_out(hi_out),
      .hi_oe_n(hi_oe_n), .ident_code(id_code), .show_rx2(show_rx2), .rx1_level(rx1_lvl),
      .rx2_level(rx2_lvl), .sel0_wire(sel0_wire), .hi_wire(hi_wire), .ident3(ident3), .rx1(rx1));

   // ----------------------------------------------------------------
   // clock, verdict and shared tasks
   // ----------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic summarize();
      if (fail_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge mclk);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         fail_count++;
      rd  = prdata[7:0];
      err = pslverr;
      lw  = lcbs_wr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chkr(input string name, input logic [3:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(name, rd, exp);
   endtask

   // select pins settle one cycle after a change; hands back on a rising edge
   task automatic pins(input logic s0, input logic [1:0] hi);
      repeat (2) @(posedge mclk);
      #1;
      chk("select_pins", {5'h00, sel0_out, hi_out}, {5'h00, s0, hi});
      @(posedge mclk);
   endtask

   // first sample in the cycle the write lands, so the whole pulse is seen
   task automatic count_pulse();
      cnt = 0;
      #1;
      repeat (P + 10)
      begin
         cnt += int'(tx);
         @(posedge mclk);
         #1;
      end
   endtask

   // watchdog: whole run is well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge mclk);
      fail_count++;
      summarize();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rstn, psel, penable, pwrite, paddr, pwdata, aux, show_rx2, rx1_lvl} = '0;
      rx2_lvl = 1'b1;
      id_code = 4'hA;
      lcbs_rd = 8'h5A;
      ir_mode = ir_xcvr_cfg_pkg::MODE_ASK;
      fail_count = 0;
      total_checks = 0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      chkr("rpc_reset", 4'h7, 8'h00);
      chkr("cxc_reset", 4'hA, 8'h00);
      chkr("tc1_ident", 4'h9, 8'h0A);
      chk("oe_n_in", 8'(({sel0_oe_n, hi_oe_n})), 8'h03);
      apb(1'b1, 4'h9, 8'h75);
      chkr("tc1_in_wr", 4'h9, 8'h7A);
      apb(1'b1, 4'h7, 8'hFF);
      chkr("rpc_rsvd", 4'h7, 8'hB8);
      chk("oe_n_out", 8'(({sel0_oe_n, hi_oe_n})), 8'h00);
      apb(1'b1, 4'h8, 8'hFF);
      chkr("cir_rsvd", 4'h8, 8'hF7);
      chk("cir_bits", 8'(({rl, ov, hc})), 8'h07);
      apb(1'b1, 4'h8, 8'h00);
      #1;
      chk("cir_clear", 8'(({rl, ov, hc})), 8'h00);
      apb(1'b1, 4'hA, 8'hFF);
      chkr("cxc_rsvd", 4'hA, 8'h77);
      // automatic selection in the ask, sir and consumer infrared modes
      apb(1'b1, 4'h9, 8'h35);
      chkr("tc1_out", 4'h9, 8'h3D);
      pins(1'b1, 2'b10);
      ir_mode <= ir_xcvr_cfg_pkg::MODE_SIR;
      pins(1'b1, 2'b01);
      apb(1'b1, 4'hA, 8'h62);
      ir_mode <= ir_xcvr_cfg_pkg::MODE_CONSUMER;
      pins(1'b0, 2'b01);
      apb(1'b1, 4'h8, 8'h20);
      pins(1'b0, 2'b11);
      chkr("mode_status", 4'hB, 8'h03);
      apb(1'b1, 4'h7, 8'h38);
      pins(1'b1, 2'b10);
      // bank-0 link control pass-through, reserved slot read and refused unmapped place
      apb(1'b1, 4'h3, 8'h3C);
      chk("lcbs_wr", {lw, lcbs_wdata[6:0]}, 8'hBC);
      chkr("lcbs_rd", 4'h3, 8'h5A);
      apb(1'b0, 4'h5, 8'h00);
      chk("rsvd_slot", {err, rd[6:0]}, 8'h00);
      apb(1'b1, 4'hC, 8'hFF);
      chk("unmapped", 8'(err), 8'h01);
      // receive path: direction, auxiliary select and inversion
      show_rx2 <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, 4'h7, {2'b00, i[2], i[1], 4'h0});
         aux <= i[0];
         repeat (5) @(posedge mclk);
         #1;
         chk("rx_data", 8'(rx_data), 8'((i[0] & ~i[2]) ^ i[1]));
      end
      // transmit pulse; the first runs out untouched, then one restart while high
      apb(1'b1, 4'h7, 8'h00);
      show_rx2 <= 1'b0;
      aux <= 1'b0;
      apb(1'b1, 4'h9, 8'h80);
      count_pulse();
      chk("pulse_len", 8'(cnt >= P && cnt <= P + 1), 8'h01);
      apb(1'b1, 4'h9, 8'h80);
      repeat (10) @(posedge mclk);
      apb(1'b1, 4'h9, 8'h80);
      apb(1'b1, 4'h9, 8'h0A);
      chkr("pulse_flag", 4'h9, 8'h8A);
      count_pulse();
      chk("pulse_restart", 8'(cnt >= P - 8 && cnt <= P + 1), 8'h01);
      summarize();
   end
endmodule // tb_top
